//--- rtl/rpmc_pkg.sv
// Constants and types for the reader power mode controller.
// Assumes a single 250 MHz core clock; all times below become cycle counts of it.
package rpmc_pkg;

    // Register offsets on the plain register port
    localparam logic [4:0] CSC_OFS  = 5'h00;   // chip_status_control
    localparam logic [4:0] RGC_OFS  = 5'h0B;   // regulator_control
    localparam logic [4:0] STAT_OFS = 5'h10;   // power state readback

    // Reset values
    localparam logic [7:0] CSC_RST = 8'h01;    // Mode 1, 5 V supply
    localparam logic [7:0] RGC_RST = 8'h87;    // Automatic regulation

    // Field positions of chip_status_control
    localparam int CSC_STBY_BIT   = 7;
    localparam int CSC_RF_BIT     = 5;
    localparam int CSC_HALF_BIT   = 4;
    localparam int CSC_RXMUX_BIT  = 3;
    localparam int CSC_RXONLY_BIT = 1;
    localparam int CSC_VSEL_BIT   = 0;

    // Clock rates
    localparam int CLK_HZ      = 250_000_000;
    localparam int AUX_CLK_HZ  = 60_000;
    localparam int XTAL_CLK_HZ = 13_560_000;
    localparam int AUX_HALF_CYC  = CLK_HZ / (2 * AUX_CLK_HZ);
    localparam int XTAL_HALF_CYC = CLK_HZ / (2 * XTAL_CLK_HZ);

    // Timing, in microseconds, and derived cycle counts (rounded down)
    localparam int CONFIRM_US = 100;
    localparam int STBY_REC_US = 100;
    localparam int MODE1_REC_US = 25;
    localparam int CONFIRM_CYC  = CLK_HZ / 1_000_000 * CONFIRM_US;
    localparam int STBY_REC_CYC = CLK_HZ / 1_000_000 * STBY_REC_US;
    localparam int MODE1_REC_CYC = CLK_HZ / 1_000_000 * MODE1_REC_US;

    // Power sequencing states
    typedef enum logic [2:0] {
        PMC_IDLE,
        PMC_START,
        PMC_CONFIRM,
        PMC_ACTIVE
    } rpmc_state_t;

endpackage

//--- rtl/rpmc_pin_sync.sv
// Three-stage synchroniser for one asynchronous pin.
// Assumes the pin is a slow level; the output follows once stages two and three agree.
`timescale 1ns/1ns
module rpmc_pin_sync (
    input  wire logic core_clk,   // Core clock
    input  wire logic rst,        // Async reset, active high
    input  wire logic pin_in,     // Raw pin level
    output logic      level_q     // Filtered level
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } rpmc_sync_t;

    rpmc_sync_t s_q;
    rpmc_sync_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // Stage one is read only by stage two, to keep metastability contained
    always_comb begin
        s_d = s_q;
        s_d.s1 = pin_in;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        if (s_q.s2 == s_q.s3) begin
            s_d.lvl = s_q.s3;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q.s1  <= 1'b0;
            s_q.s2  <= 1'b0;
            s_q.s3  <= 1'b0;
            s_q.lvl <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level_q = s_q.lvl;

endmodule

//--- rtl/rpmc_top.sv
// Power mode controller: enable pins, start-up sequence, MCU clock, RF modes.
// Assumes analog blocks report supply settling and oscillator lock as pin levels.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
module rpmc_top #(
    parameter int CONFIRM_CYCLES = rpmc_pkg::CONFIRM_CYC,    // Wake confirm window
    parameter int STBY_CYCLES    = rpmc_pkg::STBY_REC_CYC,   // Standby recovery
    parameter int MODE1_CYCLES   = rpmc_pkg::MODE1_REC_CYC   // Mode 1 recovery
) (
    input  wire logic       core_clk,          // 250 MHz core clock
    input  wire logic       rst,               // Async reset, active high
    input  wire logic       main_enable,       // Main enable pin
    input  wire logic       secondary_wake_enable, // Secondary enable pin
    input  wire logic       supplies_settled,  // Regulators settled, from analog
    input  wire logic       osc_stable,        // Crystal oscillator stable, from analog
    input  wire logic [4:0] reg_addr,          // Register address
    input  wire logic [7:0] reg_wdata,         // Register write data
    input  wire logic       reg_wr,            // Write strobe
    input  wire logic       reg_rd,            // Read strobe
    output logic      [7:0] reg_rdata,         // Read data, cycle after strobe
    output logic            mcu_clock_output,  // Clock for the host MCU
    output logic            mcu_clk_is_xtal,   // Clock output runs from crystal
    output logic            vdd_x_en,          // Auxiliary supply enable
    output logic            regulators_en,     // Main regulators enable
    output logic            osc_en,            // Crystal oscillator enable
    output logic            tx_en,             // Transmitter enable
    output logic            rx_en,             // Receiver enable
    output logic            half_power,        // Transmitter at half power
    output logic            supply_5v_sel,     // 5 V supply configuration
    output logic            rx_swap,           // Receiver input swap
    output logic      [7:0] regulator_setting, // Regulator control to analog
    output logic            ready,             // Ready to communicate
    output logic            rf_ready           // Active, not in standby, recovery wait over
);

    typedef struct packed {
        rpmc_pkg::rpmc_state_t st;
        logic [15:0]           cnt;       // Confirm window countdown
        logic [15:0]           rec;       // Mode recovery countdown
        logic [11:0]           div;       // Clock output divider
        logic                  clk;       // Clock output level
        logic                  xtal;      // Clock output from crystal
        logic                  sec_prev;  // Secondary enable, last cycle
        logic [7:0]            csc;       // chip_status_control
        logic [7:0]            rgc;       // regulator_control
        logic [7:0]            rdata;     // Read data
    } rpmc_top_t;

    rpmc_top_t s_q;
    rpmc_top_t s_d;
    logic      en_s;
    logic      sec_s;
    logic      settled_s;
    logic      stable_s;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    rpmc_pin_sync u_sync_en (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (main_enable),
        .level_q  (en_s)
    );
    rpmc_pin_sync u_sync_sec (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (secondary_wake_enable),
        .level_q  (sec_s)
    );
    rpmc_pin_sync u_sync_set (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (supplies_settled),
        .level_q  (settled_s)
    );
    rpmc_pin_sync u_sync_osc (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (osc_stable),
        .level_q  (stable_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Mode decode, shared by outputs and recovery timing
    function automatic logic mode_tx(input logic [7:0] c);
        mode_tx = !c[rpmc_pkg::CSC_STBY_BIT] && c[rpmc_pkg::CSC_RF_BIT];
    endfunction

    function automatic logic mode_rx(input logic [7:0] c);
        mode_rx = !c[rpmc_pkg::CSC_STBY_BIT]
                  && (c[rpmc_pkg::CSC_RF_BIT] || c[rpmc_pkg::CSC_RXONLY_BIT]);
    endfunction

    function automatic logic mode_one(input logic [7:0] c);
        mode_one = !c[rpmc_pkg::CSC_STBY_BIT] && !c[rpmc_pkg::CSC_RF_BIT]
                   && !c[rpmc_pkg::CSC_RXONLY_BIT];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic       active;
        logic       clk_on;
        logic [7:0] csc_n;
        active = 1'b0;
        clk_on = 1'b0;
        csc_n  = s_q.csc;
        s_d = s_q;
        s_d.sec_prev = sec_s;

        // Register port; reads answer one cycle later, unmapped reads zero
        if (reg_wr && reg_addr == rpmc_pkg::CSC_OFS) begin
            csc_n = reg_wdata;
        end
        if (reg_wr && reg_addr == rpmc_pkg::RGC_OFS) begin
            s_d.rgc = reg_wdata;
        end
        s_d.csc = csc_n;
        if (reg_rd) begin
            case (reg_addr)
                rpmc_pkg::CSC_OFS:  s_d.rdata = s_q.csc;
                rpmc_pkg::RGC_OFS:  s_d.rdata = s_q.rgc;
                rpmc_pkg::STAT_OFS: s_d.rdata = {3'h0, rf_ready, s_q.xtal, 1'b0, s_q.st[1:0]};
                default:            s_d.rdata = 8'h00;
            endcase
        end

        // Leaving standby, or leaving mode 1 for an RF mode, starts the recovery wait
        if (s_q.csc[rpmc_pkg::CSC_STBY_BIT] && !csc_n[rpmc_pkg::CSC_STBY_BIT]) begin
            s_d.rec = 16'(STBY_CYCLES);
        end else if (mode_one(s_q.csc) && !mode_one(csc_n)
                     && !csc_n[rpmc_pkg::CSC_STBY_BIT]) begin
            s_d.rec = 16'(MODE1_CYCLES);
        end else if (s_q.rec != 16'h0000) begin
            s_d.rec = s_q.rec - 16'h0001;
        end

        // Power sequencing
        case (s_q.st)
            rpmc_pkg::PMC_IDLE: begin
                s_d.xtal = 1'b0;
                if (en_s) begin
                    s_d.st = rpmc_pkg::PMC_START;
                end else if (sec_s && !s_q.sec_prev) begin
                    s_d.st = rpmc_pkg::PMC_START;
                end
            end
            rpmc_pkg::PMC_START: begin
                if (settled_s && stable_s) begin
                    s_d.xtal = 1'b1;
                    s_d.cnt  = 16'(CONFIRM_CYCLES - 1);
                    s_d.st   = en_s ? rpmc_pkg::PMC_ACTIVE : rpmc_pkg::PMC_CONFIRM;
                end
            end
            rpmc_pkg::PMC_CONFIRM: begin
                if (en_s) begin
                    s_d.st = rpmc_pkg::PMC_ACTIVE;
                end else if (s_q.cnt == 16'h0000) begin
                    s_d.st   = rpmc_pkg::PMC_IDLE;
                    s_d.xtal = 1'b0;
                end else begin
                    s_d.cnt = s_q.cnt - 16'h0001;
                end
            end
            rpmc_pkg::PMC_ACTIVE: begin
                active = 1'b1;
                if (!en_s) begin
                    s_d.st   = rpmc_pkg::PMC_IDLE;
                    s_d.xtal = 1'b0;
                end
            end
            default: begin
                s_d.st = rpmc_pkg::PMC_IDLE;
            end
        endcase

        // Clock output: aux rate until the crystal is selected, off in power down
        clk_on = s_q.xtal || sec_s || s_q.st != rpmc_pkg::PMC_IDLE;
        if (!clk_on || s_q.xtal != s_d.xtal) begin
            s_d.div = 12'h000;
            s_d.clk = 1'b0;
        end else if (s_q.div == (s_q.xtal ? 12'(rpmc_pkg::XTAL_HALF_CYC - 1)
                                          : 12'(rpmc_pkg::AUX_HALF_CYC - 1))) begin
            s_d.div = 12'h000;
            s_d.clk = !s_q.clk;
        end else begin
            s_d.div = s_q.div + 12'h001;
        end
        if (active) begin
            s_d.st = s_d.st;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q.st       <= rpmc_pkg::PMC_IDLE;
            s_q.cnt      <= 16'h0000;
            s_q.rec      <= 16'h0000;
            s_q.div      <= 12'h000;
            s_q.clk      <= 1'b0;
            s_q.xtal     <= 1'b0;
            s_q.sec_prev <= 1'b0;
            s_q.csc      <= rpmc_pkg::CSC_RST;
            s_q.rgc      <= rpmc_pkg::RGC_RST;
            s_q.rdata    <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; TX and RX enables only take effect while active, other bits pass straight through
    logic act_q;
    assign act_q             = s_q.st == rpmc_pkg::PMC_ACTIVE;
    assign reg_rdata         = s_q.rdata;
    assign mcu_clock_output  = s_q.clk;
    assign mcu_clk_is_xtal   = s_q.xtal;
    assign vdd_x_en          = sec_s || s_q.st != rpmc_pkg::PMC_IDLE;
    assign regulators_en     = s_q.st != rpmc_pkg::PMC_IDLE;
    assign osc_en            = s_q.st != rpmc_pkg::PMC_IDLE;
    assign tx_en             = act_q && mode_tx(s_q.csc);
    assign rx_en             = act_q && mode_rx(s_q.csc);
    assign half_power        = s_q.csc[rpmc_pkg::CSC_HALF_BIT];
    assign supply_5v_sel     = s_q.csc[rpmc_pkg::CSC_VSEL_BIT];
    assign rx_swap           = s_q.csc[rpmc_pkg::CSC_RXMUX_BIT];
    assign regulator_setting = s_q.rgc;
    assign ready             = act_q;
    assign rf_ready          = act_q && s_q.rec == 16'h0000
                               && !s_q.csc[rpmc_pkg::CSC_STBY_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_wake;
        s_q.st == rpmc_pkg::PMC_IDLE && !en_s && sec_s && !s_q.sec_prev;
    endsequence
    sequence s_unconfirmed;
        s_q.st == rpmc_pkg::PMC_CONFIRM && !en_s && s_q.cnt == 16'h0000;
    endsequence

    a_sleep_aux_clock: assert property (@(posedge core_clk) disable iff (rst)
        (s_q.st == rpmc_pkg::PMC_IDLE && sec_s)
            |-> vdd_x_en && !mcu_clk_is_xtal && !tx_en && !rx_en)
        else $error("sleep outputs wrong");
    a_wake_edge_start: assert property (@(posedge core_clk) disable iff (rst)
        s_wake |=> regulators_en && osc_en)
        else $error("secondary edge did not start");
    a_confirm_timeout: assert property (@(posedge core_clk) disable iff (rst)
        s_unconfirmed |=> s_q.st == rpmc_pkg::PMC_IDLE && !mcu_clk_is_xtal)
        else $error("unconfirmed wake did not power down");
    a_confirm_keeps: assert property (@(posedge core_clk) disable iff (rst)
        (s_q.st == rpmc_pkg::PMC_CONFIRM && en_s) |=> ready)
        else $error("confirmed wake not active");
    a_xtal_after_stable: assert property (@(posedge core_clk) disable iff (rst)
        $rose(mcu_clk_is_xtal) |-> $past(settled_s) && $past(stable_s))
        else $error("crystal selected too early");
    a_rf_needs_main: assert property (@(posedge core_clk) disable iff (rst)
        !ready |-> !tx_en && !rx_en)
        else $error("RF on while not active");
    a_standby_quiet: assert property (@(posedge core_clk) disable iff (rst)
        (ready && s_q.csc[rpmc_pkg::CSC_STBY_BIT]) |-> !tx_en && !rx_en && !rf_ready)
        else $error("standby not quiet");
    a_mode1_recover: assert property (@(posedge core_clk) disable iff (rst)
        (mode_one(s_q.csc) && reg_wr && reg_addr == rpmc_pkg::CSC_OFS
         && mode_tx(reg_wdata)) |=> s_q.rec == 16'(MODE1_CYCLES))
        else $error("mode 1 recovery not loaded");
    a_rx_only: assert property (@(posedge core_clk) disable iff (rst)
        (ready && s_q.csc == 8'h03) |-> rx_en && !tx_en)
        else $error("receiver only mode wrong");
    a_full_rf: assert property (@(posedge core_clk) disable iff (rst)
        (ready && s_q.csc[7] == 1'b0 && s_q.csc[5]) |-> tx_en && rx_en)
        else $error("full RF mode wrong");
    a_half_power: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && reg_addr == rpmc_pkg::CSC_OFS) |=> half_power == $past(reg_wdata[4]))
        else $error("half power bit not applied");
    a_supply_sel: assert property (@(posedge core_clk) disable iff (rst)
        (reg_wr && reg_addr == rpmc_pkg::CSC_OFS) |=> supply_5v_sel == $past(reg_wdata[0]))
        else $error("supply select not applied");
    a_confirm_load: assert property (@(posedge core_clk) disable iff (rst)
        $rose(mcu_clk_is_xtal) |-> s_q.cnt == 16'(CONFIRM_CYCLES - 1))
        else $error("confirm window not loaded");
    a_power_down_off: assert property (@(posedge core_clk) disable iff (rst)
        (s_q.st == rpmc_pkg::PMC_IDLE && !sec_s)
            |-> (!vdd_x_en && !regulators_en && !osc_en) ##1 !mcu_clock_output)
        else $error("power down not quiet");
    a_stby_recover: assert property (@(posedge core_clk) disable iff (rst)
        (s_q.csc[rpmc_pkg::CSC_STBY_BIT] && reg_wr && reg_addr == rpmc_pkg::CSC_OFS
         && !reg_wdata[rpmc_pkg::CSC_STBY_BIT]) |=> s_q.rec == 16'(STBY_CYCLES))
        else $error("standby recovery not loaded");
    a_mode1_rf_off: assert property (@(posedge core_clk) disable iff (rst)
        (ready && mode_one(s_q.csc)) |-> !tx_en && !rx_en)
        else $error("mode 1 RF not off");

endmodule

//--- test/rpmc_host_model.sv
// Host MCU and analog stand-in: drives both enable pins and the settle flags.
// Assumes the bench states wanted pin levels; the model applies them one at a time.
`timescale 1ns/1ns
module rpmc_host_model #(
    parameter int GAP_CYCLES    = 8,   // Shortened pin separation
    parameter int SETTLE_CYCLES = 30   // Regulator and oscillator settle time
) (
    input  wire logic core_clk,              // Core clock
    input  wire logic rst,                   // Async reset, active high
    input  wire logic want_en,               // Wanted main enable level
    input  wire logic want_sec,              // Wanted secondary enable level
    input  wire logic regulators_en,         // From device
    input  wire logic osc_en,                // From device
    output logic      main_enable,           // Main enable pin
    output logic      secondary_wake_enable, // Secondary enable pin
    output logic      supplies_settled,      // Analog settled flag
    output logic      osc_stable             // Analog stable flag
);
    int gap_q;
    int reg_cnt_q;
    int osc_cnt_q;
    ////////////////////////////////////////////////////////////////////////////////
    // One pin change per gap, so both never rise together
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gap_q                 <= 0;
            main_enable           <= 1'b0;
            secondary_wake_enable <= 1'b0;
        end else if (gap_q != 0) begin
            gap_q <= gap_q - 1;
        end else if (secondary_wake_enable != want_sec) begin
            secondary_wake_enable <= want_sec;
            gap_q                 <= GAP_CYCLES;
        end else if (main_enable != want_en) begin
            main_enable <= want_en;
            gap_q       <= GAP_CYCLES;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Settle flags follow enables after a delay, drop at once
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_cnt_q <= 0;
            osc_cnt_q <= 0;
        end else begin
            reg_cnt_q <= regulators_en ? reg_cnt_q + 1 : 0;
            osc_cnt_q <= osc_en ? osc_cnt_q + 1 : 0;
        end
    end
    assign supplies_settled = (reg_cnt_q >= SETTLE_CYCLES);
    assign osc_stable       = (osc_cnt_q >= SETTLE_CYCLES);
endmodule

//--- test/rpmc_top_tb.sv
// Self-checking bench for the power mode controller.
// Assumes shortened confirm and recovery counts; host model owns the pins.
`timescale 1ns/1ns
module rpmc_top_tb;
    localparam int CONF = 50;
    localparam int STBY = 40;
    localparam int M1   = 20;
    logic       core_clk  = 1'b0;
    logic       rst       = 1'b0;
    logic       want_en   = 1'b0;
    logic       want_sec  = 1'b0;
    logic [4:0] reg_addr  = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic       en, sec, settled, stable, mclk, xtal, vddx, regs, osc, tx, rx, half, v5, swp;
    logic       rdy, rfr;
    logic [7:0] rdata, rgset, d;
    int         err_count  = 0;
    int         n_compared = 0;
    always #2 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////////
    rpmc_host_model host (.core_clk(core_clk), .rst(rst), .want_en(want_en),
        .want_sec(want_sec), .regulators_en(regs), .osc_en(osc), .main_enable(en),
        .secondary_wake_enable(sec), .supplies_settled(settled), .osc_stable(stable));
    rpmc_top #(.CONFIRM_CYCLES(CONF), .STBY_CYCLES(STBY), .MODE1_CYCLES(M1)) dut (
        .core_clk(core_clk), .rst(rst), .main_enable(en), .secondary_wake_enable(sec),
        .supplies_settled(settled), .osc_stable(stable), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .mcu_clock_output(mclk), .mcu_clk_is_xtal(xtal), .vdd_x_en(vddx),
        .regulators_en(regs), .osc_en(osc), .tx_en(tx), .rx_en(rx), .half_power(half),
        .supply_5v_sel(v5), .rx_swap(swp), .regulator_setting(rgset), .ready(rdy),
        .rf_ready(rfr));
    ////////////////////////////////////////////////////////////////////////////////
    // Shared comparison and bus tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = rdata;
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return regs;
            1: return xtal;
            2: return rdy;
            default: return rfr;
        endcase
    endfunction
    // Bounded wait; running out is a mismatch
    task automatic wait_on(input int w, input logic v, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge core_clk);
            #1;
            if (pick(w) === v) return;
        end
        check(8'h00, 8'h01);
    endtask
    task automatic toggles(input int n, output logic [7:0] t);
        logic last;
        t = 8'h00;
        @(posedge core_clk);
        #1 last = mclk;
        repeat (n) begin
            @(posedge core_clk);
            #1;
            if (mclk !== last) t++;
            last = mclk;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs();
        rd(5'h00, d); check(d, 8'h01);
        rd(5'h0B, d); check(d, 8'h87);
        rd(5'h10, d); check(d, 8'h00);
        check({vddx, mclk, v5}, 8'h01);
        wr(5'h0B, 8'h07);
        wr(5'h10, 8'hFF);
        wr(5'h05, 8'hFF);
        rd(5'h0B, d); check(d, 8'h07);
        check(rgset, 8'h07);
        rd(5'h05, d); check(d, 8'h00);
        rd(5'h10, d); check(d, 8'h00);
        wr(5'h00, 8'h08);
        #1 check({v5, swp}, 8'h01);
        wr(5'h00, 8'h01);
    endtask
    task automatic t_wake_lost();
        @(posedge core_clk);
        want_sec <= 1'b1;
        wait_on(0, 1'b1, 30);
        check({xtal, osc}, 8'h01);
        wait_on(1, 1'b1, 100);
        check(rdy, 8'h00);
        repeat (CONF - 5) @(posedge core_clk);
        #1 check(regs, 8'h01);
        wait_on(0, 1'b0, 20);
        check({xtal, vddx, tx, rx}, 8'h04);
        toggles(4166, d); check(d, 8'h02);
        @(posedge core_clk);
        want_sec <= 1'b0;
        repeat (30) @(posedge core_clk);
        #1 check({vddx, regs, osc, mclk}, 8'h00);
    endtask
    task automatic t_wake_kept();
        @(posedge core_clk);
        want_sec <= 1'b1;
        wait_on(1, 1'b1, 200);
        @(posedge core_clk);
        want_en <= 1'b1;
        wait_on(2, 1'b1, 40);
        repeat (CONF + 20) @(posedge core_clk);
        #1 check(rdy, 8'h01);
        rd(5'h10, d); check(d & 8'h0B, 8'h0B);
        toggles(90, d); check(d, 8'h0A);
        @(posedge core_clk);
        want_sec <= 1'b0;
    endtask
    // Mode table: register value, then {tx, rx, half}
    task automatic t_modes();
        logic [7:0] cs [5] = '{8'h21, 8'h31, 8'h03, 8'h01, 8'h81};
        logic [2:0] ex [5] = '{3'b110, 3'b111, 3'b010, 3'b000, 3'b000};
        for (int i = 0; i < 5; i++) begin
            wr(5'h00, cs[i]);
            #1 check({tx, rx, half}, ex[i]);
        end
        wr(5'h00, 8'h21);
        #1 check(rfr, 8'h00);
        wait_on(3, 1'b1, STBY + 10);
        wr(5'h01, 8'h00);
        wr(5'h00, 8'h01);
        wr(5'h00, 8'h21);
        #1 check(rfr, 8'h00);
        wait_on(3, 1'b1, M1 + 10);
        @(posedge core_clk);
        want_en <= 1'b0;
        wait_on(0, 1'b0, 40);
        check({tx, rx, rdy}, 8'h00);
    endtask
    task automatic t_direct();
        @(posedge core_clk);
        want_en <= 1'b1;
        wait_on(0, 1'b1, 30);
        check(xtal, 8'h00);
        wait_on(2, 1'b1, 100);
        check(xtal, 8'h01);
        @(posedge core_clk);
        want_en <= 1'b0;
        wait_on(0, 1'b0, 40);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        rst = 1'b1;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_wake_lost();
        t_wake_kept();
        t_modes();
        t_direct();
        close_out();
    end
    initial begin
        #100000;
        err_count++;
        close_out();
    end
endmodule
